// [hdl/hwmon_scan_pkg.sv]
// constants and types for the hardware monitor measurement scan block
// ****************************************************************
// ****************************************************************
package hwmon_scan_pkg;
  // register indices; the byte address is the index times four
  localparam logic [7:0] IDX_TEMP_DATA = 8'h09;
  localparam logic [7:0] IDX_TEMP_CTRL = 8'h0A;
  localparam logic [7:0] IDX_VOLT_CAPS = 8'h10;
  localparam logic [7:0] IDX_VOLT_READ = 8'h11;
  localparam logic [7:0] IDX_VOLT_CTRL = 8'h12;
  localparam logic [7:0] IDX_DEV_STATUS = 8'h20;
  localparam logic [7:0] IDX_SCAN_MODE = 8'h21;
  localparam logic [7:0] IDX_FUNC_TYPE = 8'h22;
  // field positions
  localparam int TC_ATTN = 0;
  localparam int TC_LOCAL = 1;
  localparam int TC_REMOTE = 2;
  localparam int VC_ATTN = 0;
  localparam int VC_EN_LO = 1;
  localparam int ST_FRESH = 0;
  localparam int ST_OVERRUN = 1;
  // reset and fixed values
  localparam logic [15:0] TEMP_CTRL_RST = 16'h0000;
  localparam logic [15:0] VOLT_CTRL_RST = 16'h001F;
  localparam logic [15:0] VOLT_CAPS_VAL = 16'h0051;
  localparam logic [3:0] FUNC_TYPE_VOLT = 4'h2;
  localparam logic [9:0] TEMP_CODE_MIN = 10'h200;
  localparam logic [9:0] TEMP_CODE_MIN_HALF = 10'h201;
  localparam logic [8:0] VOLT_FULL = 9'h1FF;
  localparam logic [8:0] VOLT_ZERO = 9'h000;
  localparam int NUM_VIN = 5;
  // timing: one input slot, whole scan well under 250 ms
  localparam real CLK_NS = 40.0;
  localparam real SLOT_US = 10000.0;
  localparam int SLOT_CYCLES = int'(SLOT_US * 1000.0 / CLK_NS);
  localparam int LOW_POWER_DIV = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic remoteSensorOn;
    logic localSensorOn;
    logic attnAllow;
  } temp_ctrl_t;

  typedef struct packed {
    logic [8:0] code;
    logic over;
    logic under;
  } adc_sample_t;

  typedef enum logic [1:0] {IDLE, CONVERT, STORE} scan_state_t;
endpackage : hwmon_scan_pkg

// [hdl/hwmon_measurement_scan.sv]
// voltage scan, readout latch and axi4-lite register slave
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
module hwmon_measurement_scan #(
  parameter int SLOT_LEN = hwmon_scan_pkg::SLOT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // converter and temperature front end
  input wire hwmon_scan_pkg::adc_sample_t adcSample,
  input wire logic adcDone,
  output logic adcStart,
  output logic [2:0] adcChannel,
  input wire logic [9:0] tempCode,
  input wire logic tempFault,
  // power mode and bus attention
  input wire logic lowPower,
  output logic functionEvent,
  output logic attnRequest,
  output logic localSensorOn,
  output logic remoteSensorOn
);
  import hwmon_scan_pkg::*;

  typedef struct packed {
    temp_ctrl_t tempCtrl;
    logic voltAttn;
    logic [NUM_VIN-1:0] vinOn;
    logic lowRate;
    logic [8:0] voltResult;
    logic [2:0] sensorIndex;
    logic freshVoltageFlag;
    logic voltageOverrunFlag;
    logic unread;
    scan_state_t state;
    logic [2:0] chan;
    logic [31:0] timer;
    logic [1:0] lpCount;
    logic event_;
    logic lpLevelA;
    logic lpLevelB;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bv;
    logic [1:0] bResp;
    logic rv;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_t;

  state_t s;
  state_t next_s;
  logic [2:0] nextChan;
  logic anyOn;
  logic [8:0] satCode;
  logic doWrite;
  logic doRead;
  logic [15:0] readWord;
  logic readOk;
  logic readClears;
  logic [7:0] rdIdx;
  logic [7:0] wrIdx;

  // ****************************************************************
  // next enabled input above the current one, wrapping
  // ****************************************************************
  always_comb begin
    nextChan = s.chan;
    for (int k = NUM_VIN; k >= 1; k--) begin
      if (s.vinOn[(int'(s.chan) + k) % NUM_VIN]) begin
        nextChan = 3'((int'(s.chan) + k) % NUM_VIN);
      end
    end
  end

  assign anyOn = |s.vinOn;

  // word index of each request, byte lanes dropped
  assign rdIdx = {2'b00, araddr[7:2]};
  assign wrIdx = {2'b00, s.awAddr[7:2]};

  // ****************************************************************
  // saturation of converter result
  // ****************************************************************
  always_comb begin
    if (adcSample.over) begin
      satCode = VOLT_FULL;
    end else if (adcSample.under) begin
      satCode = VOLT_ZERO;
    end else begin
      satCode = adcSample.code;
    end
  end

  // ****************************************************************
  // register read decode
  // ****************************************************************
  always_comb begin
    readWord = 16'h0000;
    readOk = 1'b1;
    readClears = 1'b0;
    if (araddr[1:0] != 2'b00) begin
      readOk = 1'b0;
    end else if (rdIdx == IDX_TEMP_DATA) begin
      readWord = {tempFault ? TEMP_CODE_MIN : tempCode, 6'h00};
    end else if (rdIdx == IDX_TEMP_CTRL) begin
      readWord = {13'h0000, s.tempCtrl};
    end else if (rdIdx == IDX_VOLT_CAPS) begin
      readWord = VOLT_CAPS_VAL;
    end else if (rdIdx == IDX_VOLT_READ) begin
      readWord = {s.voltResult, 2'b00, s.sensorIndex, 2'b00};
      readClears = 1'b1;
    end else if (rdIdx == IDX_VOLT_CTRL) begin
      readWord = {10'h000, s.vinOn, s.voltAttn};
    end else if (rdIdx == IDX_DEV_STATUS) begin
      readWord = {14'h0000, s.voltageOverrunFlag, s.freshVoltageFlag};
    end else if (rdIdx == IDX_SCAN_MODE) begin
      readWord = {15'h0000, s.lowRate};
    end else if (rdIdx == IDX_FUNC_TYPE) begin
      readWord = {12'h000, FUNC_TYPE_VOLT};
    end else begin
      readOk = 1'b0;
    end
  end

  assign doWrite = s.awHeld && s.wHeld && !s.bv;
  assign doRead = arvalid && !s.rv;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.event_ = 1'b0;
    next_s.lpLevelA = lowPower;
    next_s.lpLevelB = s.lpLevelA;
    // write channel capture
    if (awvalid && !s.awHeld) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && !s.wHeld) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (doWrite) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bv = 1'b1;
      next_s.bResp = RESP_OKAY;
      if (s.awAddr[1:0] != 2'b00) begin
        next_s.bResp = RESP_SLVERR;
      end else if (wrIdx == IDX_TEMP_CTRL) begin
        if (s.wStrb[0]) begin
          next_s.tempCtrl.attnAllow = s.wData[TC_ATTN];
          next_s.tempCtrl.localSensorOn = s.wData[TC_LOCAL];
          next_s.tempCtrl.remoteSensorOn = s.wData[TC_REMOTE];
        end
      end else if (wrIdx == IDX_VOLT_CTRL) begin
        if (s.wStrb[0]) begin
          next_s.voltAttn = s.wData[VC_ATTN];
          next_s.vinOn = s.wData[VC_EN_LO +: NUM_VIN];
        end
      end else if (wrIdx == IDX_SCAN_MODE) begin
        if (s.wStrb[0]) begin
          next_s.lowRate = s.wData[0];
        end
      end else if (wrIdx == IDX_TEMP_DATA || wrIdx == IDX_VOLT_CAPS ||
                   wrIdx == IDX_VOLT_READ || wrIdx == IDX_DEV_STATUS ||
                   wrIdx == IDX_FUNC_TYPE) begin
        next_s.bResp = RESP_OKAY;
      end else begin
        next_s.bResp = RESP_SLVERR;
      end
    end
    if (s.bv && bready) begin
      next_s.bv = 1'b0;
    end
    // read channel
    if (doRead) begin
      next_s.rv = 1'b1;
      next_s.rData = {16'h0000, readWord};
      next_s.rResp = readOk ? RESP_OKAY : RESP_SLVERR;
      if (readClears) begin
        next_s.freshVoltageFlag = 1'b0;
        next_s.voltageOverrunFlag = 1'b0;
        next_s.unread = 1'b0;
      end
    end
    if (s.rv && rready) begin
      next_s.rv = 1'b0;
    end
    // scan sequencer: one slot per input, slower in low power
    case (s.state)
      IDLE: begin
        next_s.timer = 32'd0;
        if (anyOn) begin
          next_s.chan = s.vinOn[s.chan] ? s.chan : nextChan;
          next_s.state = CONVERT;
        end
      end
      CONVERT: begin
        if (s.timer < 32'(SLOT_LEN)) begin
          next_s.timer = s.timer + 32'd1;
        end
        if (!anyOn) begin
          next_s.state = IDLE;
        end else if (adcDone && s.timer >= 32'(SLOT_LEN - 1)) begin
          if (!(s.lowRate || s.lpLevelB) ||
              s.lpCount == 2'(LOW_POWER_DIV - 1)) begin
            next_s.state = STORE;
          end else begin
            next_s.timer = 32'd0;
          end
          next_s.lpCount = s.lpCount + 2'd1;
        end
      end
      STORE: begin
        next_s.voltResult = satCode;
        next_s.sensorIndex = s.chan;
        next_s.event_ = 1'b1;
        next_s.freshVoltageFlag = 1'b1;
        next_s.unread = 1'b1;
        if (s.unread) begin
          next_s.voltageOverrunFlag = 1'b1;
        end
        next_s.lpCount = 2'd0;
        next_s.chan = nextChan;
        next_s.timer = 32'd0;
        next_s.state = anyOn ? CONVERT : IDLE;
      end
      default: begin
        next_s.state = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.tempCtrl <= temp_ctrl_t'(TEMP_CTRL_RST[2:0]);
      s.vinOn <= VOLT_CTRL_RST[VC_EN_LO +: NUM_VIN];
      s.voltAttn <= VOLT_CTRL_RST[VC_ATTN];
      s.state <= IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign awready = !s.awHeld;
  assign wready = !s.wHeld;
  assign bvalid = s.bv;
  assign bresp = s.bResp;
  assign arready = !s.rv;
  assign rvalid = s.rv;
  assign rdata = s.rData;
  assign rresp = s.rResp;
  assign adcStart = (s.state == CONVERT) && (s.timer == 32'd0);
  assign adcChannel = s.chan;
  assign functionEvent = s.event_;
  assign attnRequest = (s.event_ && s.voltAttn) ||
    (s.tempCtrl.attnAllow &&
     (s.tempCtrl.localSensorOn || s.tempCtrl.remoteSensorOn));
  assign localSensorOn = s.tempCtrl.localSensorOn;
  assign remoteSensorOn = s.tempCtrl.remoteSensorOn;
endmodule : hwmon_measurement_scan

// [verification/hwmon_scan_monitor.sv]
// port checker for the measurement scan block
`timescale 1ns/100ps
module hwmon_scan_monitor #(
  parameter int SLOT_LEN = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // scan and attention
  input wire logic adcStart,
  input wire logic [2:0] adcChannel,
  input wire logic functionEvent,
  input wire logic attnRequest,
  input wire logic localSensorOn,
  input wire logic remoteSensorOn
);
  import hwmon_scan_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_event_pulse: assert property (functionEvent |=> !functionEvent)
    else $error("event longer than one cycle");
  a_slot_gap: assert property (adcStart |=> !adcStart [*3])
    else $error("slots too close");
  a_chan_range: assert property (adcStart |-> adcChannel < 3'h5)
    else $error("channel out of range");
  a_temp_reset: assert property (disable iff (1'h0)
    rst |=> !localSensorOn && !remoteSensorOn)
    else $error("sensor enables not cleared");
  a_attn_gate: assert property (!functionEvent && !localSensorOn
    && !remoteSensorOn |-> !attnRequest)
    else $error("attention without cause");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |=> ##1 bvalid)
    else $error("write answer late");
  a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  c_event: cover property (functionEvent);
  c_attn: cover property (functionEvent && attnRequest);
  c_refused: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : hwmon_scan_monitor

bind hwmon_measurement_scan hwmon_scan_monitor #(.SLOT_LEN(SLOT_LEN)) mon (
  .clk_sys(clk_sys), .rst(rst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp),
  .adcStart(adcStart), .adcChannel(adcChannel),
  .functionEvent(functionEvent), .attnRequest(attnRequest),
  .localSensorOn(localSensorOn), .remoteSensorOn(remoteSensorOn)
);

// [verification/adc_front_model.sv]
// converter front end answering each conversion slot
`timescale 1ns/100ps
module adc_front_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // conversion
  input wire logic adcStart,
  input wire logic [2:0] adcChannel,
  output hwmon_scan_pkg::adc_sample_t adcSample,
  output logic adcDone
);
  import hwmon_scan_pkg::*;
  logic [3:0] busy;
  logic [8:0] junk = 9'h155;
  // latency grows with channel number
  always @(posedge clk_sys) begin
    junk <= ~junk;
    if (rst) begin
      busy <= 4'h0;
      adcDone <= 1'h0;
    end else if (adcStart) begin
      busy <= {1'h0, adcChannel} + 4'h1;
      adcDone <= 1'h0;
    end else if (busy != 4'h0) begin
      busy <= busy - 4'h1;
      adcDone <= (busy == 4'h1);
    end
  end
  // channel 0 under range, channel 4 over range
  always_comb begin
    adcSample = '{code: junk, over: 1'h0, under: 1'h0};
    if (adcDone)
      adcSample = '{code: {adcChannel, 6'h15}, over: (adcChannel == 3'h4),
        under: (adcChannel == 3'h0)};
  end
endmodule : adc_front_model

// [verification/tb_hwmon_measurement_scan.sv]
// self-checking bench for the measurement scan block
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    samplesChecked++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module tb_hwmon_measurement_scan;
  import hwmon_scan_pkg::*;
  logic clk_sys = 1'h0, rst = 1'h1, tempFault = 1'h0, lowPower = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [9:0] tempCode = 10'h000;
  logic awready, wready, bvalid, arready, rvalid, adcStart, adcDone;
  logic functionEvent, attnRequest, localSensorOn, remoteSensorOn;
  logic [1:0] bresp, rresp, r;
  logic [2:0] adcChannel;
  adc_sample_t adcSample;
  int mismatches = 0, samplesChecked = 0, cyc = 0;
  hwmon_measurement_scan #(.SLOT_LEN(16)) dut (
    .clk_sys(clk_sys), .rst(rst), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(1'h1), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(1'h1), .rdata(rdata), .rresp(rresp), .adcSample(adcSample),
    .adcDone(adcDone), .adcStart(adcStart), .adcChannel(adcChannel),
    .tempCode(tempCode), .tempFault(tempFault), .lowPower(lowPower),
    .functionEvent(functionEvent), .attnRequest(attnRequest),
    .localSensorOn(localSensorOn), .remoteSensorOn(remoteSensorOn));
  adc_front_model adc (.clk_sys(clk_sys), .rst(rst), .adcStart(adcStart),
    .adcChannel(adcChannel), .adcSample(adcSample), .adcDone(adcDone));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= {a[5:0], 2'b00};
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
  endtask : wr
  task rd(input logic [7:0] a);
    araddr <= {a[5:0], 2'b00};
    arvalid <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
  task ev;
    do @(posedge clk_sys); while (!functionEvent);
  endtask : ev
  function automatic int nxt(input int p, input logic [4:0] m);
    for (int i = 1; i <= 5; i++) begin
      if (m[(p + i) % 5]) return (p + i) % 5;
    end
    return p;
  endfunction : nxt
  function automatic logic [31:0] expRead(input int c);
    logic [8:0] v;
    v = (c == 0) ? 9'h000 : (c == 4) ? 9'h1FF : {3'(c), 6'h15};
    return {16'h0000, v, 2'h0, 3'(c), 2'h0};
  endfunction : expRead
  task t_regs;
    rd(IDX_TEMP_CTRL);
    `CHK(d, 32'h0)
    rd(IDX_FUNC_TYPE);
    `CHK(d, 32'h2)
    rd(8'h30);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
  endtask : t_regs
  task t_temp;
    wr(IDX_TEMP_CTRL, 32'hFFFF_FFFF);
    rd(IDX_TEMP_CTRL);
    `CHK(d, 32'h7)
    `CHK({localSensorOn, remoteSensorOn, attnRequest}, 3'h7)
    wr(IDX_TEMP_CTRL, 32'h2);
    `CHK({localSensorOn, remoteSensorOn, attnRequest}, 3'h4)
    wr(IDX_TEMP_CTRL, 32'h1);
    `CHK(attnRequest, 1'h0)
    rd(IDX_TEMP_CTRL);
    `CHK(d, 32'h1)
    tempFault <= 1'h1;
    rd(IDX_TEMP_DATA);
    `CHK(d, 32'h8000)
    tempFault <= 1'h0;
    tempCode <= 10'h201;
    rd(IDX_TEMP_DATA);
    `CHK(d, 32'h8040)
  endtask : t_temp
  task t_scan(input logic [4:0] m, input logic at);
    int p;
    wr(IDX_VOLT_CTRL, {26'h0, m, at});
    repeat (2) begin
      ev;
      rd(IDX_VOLT_READ);
    end
    p = int'(d[4:2]);
    repeat (6) begin
      ev;
      `CHK(attnRequest, at)
      rd(IDX_VOLT_READ);
      p = nxt(p, m);
      `CHK(d, expRead(p))
      rd(IDX_DEV_STATUS);
      `CHK(d[1:0], 2'h0)
    end
  endtask : t_scan
  task t_overrun;
    ev;
    ev;
    rd(IDX_DEV_STATUS);
    `CHK(d, 32'h3)
    rd(IDX_VOLT_READ);
    rd(IDX_DEV_STATUS);
    `CHK(d, 32'h0)
  endtask : t_overrun
  task gap(output int g);
    ev;
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (!functionEvent);
  endtask : gap
  task t_low_power;
    int g0, g1;
    wr(IDX_VOLT_CTRL, 32'h3E);
    gap(g0);
    lowPower <= 1'h1;
    ev;
    ev;
    gap(g1);
    `CHK(g1 >= 3 * g0, 1'h1)
    lowPower <= 1'h0;
  endtask : t_low_power
  task t_idle;
    int n;
    wr(IDX_VOLT_CTRL, 32'h1);
    repeat (30) @(posedge clk_sys);
    n = 0;
    repeat (100) begin
      @(posedge clk_sys);
      if (functionEvent || adcStart) n++;
    end
    `CHK(n, 0)
  endtask : t_idle
  task results;
    $display("mismatches %0d checked %0d", mismatches, samplesChecked);
    if (mismatches == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    t_regs;
    t_temp;
    t_scan(5'h15, 1'h1);
    t_scan(5'h0A, 1'h0);
    t_overrun;
    t_low_power;
    t_idle;
    results;
  end
endmodule : tb_hwmon_measurement_scan
